// [core/twh_pkg.sv]
`default_nettype none
package twh_pkg;

  // Host command codes and reader/writer response code.
  localparam logic [7:0] CMD_QUERY      = 8'h28;
  localparam logic [7:0] CMD_ANSWER_OK  = 8'hf8;
  localparam logic [7:0] CMD_ANSWER_ERR = 8'he8;
  localparam logic [7:0] RF_WRITE_RESP  = 8'h09;

  // Serial status codes returned to the host.
  localparam logic [7:0] STATUS_OK      = 8'h00;
  localparam logic [7:0] STATUS_BUSY    = 8'h01;

  // Status flag bytes and status words sent to the reader/writer.
  localparam logic [7:0] FLAG1_OK       = 8'h00;
  localparam logic [7:0] FLAG2_OK       = 8'h00;
  localparam logic [7:0] FLAG1_ERR      = 8'h01;
  localparam logic [7:0] FLAG2_ERR      = 8'h01;
  localparam logic [7:0] SW1_OK         = 8'h90;
  localparam logic [7:0] SW2_OK         = 8'h00;
  localparam logic [7:0] SW1_ERR        = 8'h6f;
  localparam logic [7:0] SW2_ERR        = 8'h00;

  // Frame sizes in bytes.
  localparam int         ID_BYTES       = 8;
  localparam logic [8:0] QUERY_HDR      = 9'h004;
  localparam logic [3:0] JIS_RESP_LEN   = 4'hb;
  localparam logic [3:0] TYPEB_RESP_LEN = 4'h2;

  // Answer-wait time and its cycle count at the core clock.
  localparam int         CLK_HZ         = 20_000_000;
  localparam int         ANSWER_WAIT_MS = 100;
  localparam int         AWT_CYCLES     = ANSWER_WAIT_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RF_RX,
    ST_WAIT_QUERY,
    ST_SEND_QUERY,
    ST_ANSWER_WAIT,
    ST_RF_RESP
  } twh_state_t;

  typedef enum logic [1:0] {
    REP_BUSY,
    REP_STATUS,
    REP_QUERY
  } twh_reply_t;

endpackage
`default_nettype wire

// [core/twh_sync2.sv]
`default_nettype none
module twh_sync2 (
  // Clock and control
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  // Level crossing
  input  wire logic din,
  output logic      dout
);

  logic stage1;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end
    else if (ce)
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule
`default_nettype wire

// [core/twh_awt_timer.sv]
`default_nettype none
module twh_awt_timer #(
  parameter int COUNT = 2_000_000
) (
  // Clock and control
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  // Timer control
  input  wire logic run,
  input  wire logic restart,
  output logic      expired
);

  localparam int W = $clog2(COUNT + 1);

  logic [W-1:0] count;

  // The count reloads whenever the timer is idle or restarted.
  always_ff @(posedge mclk)
  begin
    if (rst)
      count <= W'(COUNT - 1);
    else if (ce)
    begin
      if (!run || restart)
        count <= W'(COUNT - 1);
      else if (count != '0)
        count <= count - W'(1);
    end
  end

  assign expired = run && !restart && (count == '0);

endmodule
`default_nettype wire

// [core/twh_core.sv]
// Functional notes
// - QUERY reply: status, start address high then low, length n, n bytes.
// - ANSWER is answered with exactly one status byte.
// - RF write response: 0x09, 8-byte id, two flags; Type B only SW1 SW2.
// - During an operation-mode command no further command is processed.
// - Exclusive window runs from command start to end of its response.
// - Tunnel window runs from RF command start to end of RF response.
// - Address-matched host commands get BUSY during exclusive control.
// - Unimplemented host command codes get BUSY.
// - Serial processing: BUSY to host, silence to reader/writer commands.
// - Host command during RF reception: BUSY first, interrupt afterwards.
// - After the interrupt every host command except QUERY gets BUSY.
// - Carrier loss returns any tunnel state to idle.
// - In answer wait each BUSY reply restarts the answer-wait timer.
// - BUSY replies faster than the wait time prevent timeout.
// - ANSWER ends the answer-wait state.
`default_nettype none
module twh_core #(
  parameter int AWT_COUNT = twh_pkg::AWT_CYCLES,
  parameter int MEM_DEPTH = 256
) (
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Host command bytes from the serial slave
  input  wire logic        host_cmd_valid,
  input  wire logic [7:0]  host_cmd_code,
  input  wire logic        host_addr_match,
  input  wire logic        host_code_known,
  input  wire logic        serial_busy,
  output logic             host_cmd_fwd,
  // Host reply bytes to the serial slave
  output logic             host_tx_valid,
  output logic [7:0]       host_tx_data,
  output logic             host_tx_last,
  input  wire logic        host_tx_ready,
  output logic             host_interrupt_out_n,
  // Reader/writer tunnel write command
  input  wire logic        rf_carrier,
  input  wire logic        rf_cmd_start,
  input  wire logic        rf_type_b,
  input  wire logic [15:0] rf_wr_addr,
  input  wire logic [7:0]  rf_wr_len,
  input  wire logic        rf_data_valid,
  input  wire logic [7:0]  rf_data,
  input  wire logic        rf_cmd_done,
  input  wire logic [63:0] card_id,
  // Reader/writer response bytes
  output logic             rf_tx_valid,
  output logic [7:0]       rf_tx_data,
  output logic             rf_tx_last,
  input  wire logic        rf_tx_ready,
  // Status
  output logic             excl_active
);

  localparam int AW = $clog2(MEM_DEPTH);

  twh_pkg::twh_state_t state;
  twh_pkg::twh_reply_t h_kind;
  twh_pkg::twh_reply_t h_kind_new;
  twh_pkg::twh_reply_t kind_sel;

  logic [7:0]    mem [MEM_DEPTH];
  logic [AW-1:0] wptr;
  logic [15:0]   addr_r;
  logic [7:0]    len_r;
  logic          type_b_r;
  logic          done_seen;
  logic          ans_ok;
  logic          ok_sel;
  logic          carrier_q;
  logic          hcmd;
  logic          h_start;
  logic          fwd;
  logic [8:0]    h_idx;
  logic [8:0]    h_sel;
  logic [8:0]    h_total;
  logic [7:0]    h_byte;
  logic [3:0]    r_idx;
  logic [3:0]    r_sel;
  logic [3:0]    r_total;
  logic [7:0]    r_byte;
  logic          r_start;
  logic          is_answer;
  logic          go_irq;
  logic          lost;
  logic          awt_restart;
  logic          awt_expired;

  twh_sync2 u_carrier_sync (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .din  (rf_carrier),
    .dout (carrier_q)
  );

  twh_awt_timer #(
    .COUNT (AWT_COUNT)
  ) u_awt (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .run     (state == twh_pkg::ST_ANSWER_WAIT),
    .restart (awt_restart),
    .expired (awt_expired)
  );

  // A host command is handled only when the reply channel is free.
  assign hcmd = ce && host_cmd_valid && host_addr_match && !host_tx_valid;
  assign is_answer = (host_cmd_code == twh_pkg::CMD_ANSWER_OK) ||
                     (host_cmd_code == twh_pkg::CMD_ANSWER_ERR);
  assign lost = ce && !carrier_q && (state != twh_pkg::ST_IDLE);
  assign r_start = hcmd && is_answer && (state == twh_pkg::ST_ANSWER_WAIT);
  assign awt_restart = hcmd && !is_answer &&
                       (state == twh_pkg::ST_ANSWER_WAIT);
  // The interrupt waits until any BUSY reply in flight has left.
  assign go_irq = ce && (state == twh_pkg::ST_RF_RX) && carrier_q &&
                  (rf_cmd_done || done_seen) && !hcmd &&
                  !host_tx_valid;

  // Reply selection for an accepted host command.
  always_comb
  begin
    h_start    = 1'b0;
    fwd        = 1'b0;
    h_kind_new = twh_pkg::REP_BUSY;
    if (hcmd)
    begin
      h_start = 1'b1;
      unique case (state)
        twh_pkg::ST_IDLE:
        begin
          if (!serial_busy && host_code_known)
          begin
            h_start = 1'b0;
            fwd     = 1'b1;
          end
        end
        twh_pkg::ST_WAIT_QUERY:
          if (host_cmd_code == twh_pkg::CMD_QUERY)
            h_kind_new = twh_pkg::REP_QUERY;
        twh_pkg::ST_SEND_QUERY:
          h_start = 1'b0;
        twh_pkg::ST_ANSWER_WAIT:
          if (is_answer)
            h_kind_new = twh_pkg::REP_STATUS;
        twh_pkg::ST_RF_RX,
        twh_pkg::ST_RF_RESP:
          h_kind_new = twh_pkg::REP_BUSY;
      endcase
    end
  end

  // Host reply byte for the slot about to be presented.
  always_comb
  begin
    kind_sel = h_start ? h_kind_new : h_kind;
    h_sel    = h_start ? 9'h000 : h_idx + 9'h001;
    h_total  = (kind_sel == twh_pkg::REP_QUERY) ?
               twh_pkg::QUERY_HDR + {1'b0, len_r} : 9'h001;
    h_byte   = twh_pkg::STATUS_BUSY;
    unique case (kind_sel)
      twh_pkg::REP_BUSY:
        h_byte = twh_pkg::STATUS_BUSY;
      twh_pkg::REP_STATUS:
        h_byte = twh_pkg::STATUS_OK;
      twh_pkg::REP_QUERY:
      begin
        unique case (h_sel)
          9'h000:  h_byte = twh_pkg::STATUS_OK;
          9'h001:  h_byte = addr_r[15:8];
          9'h002:  h_byte = addr_r[7:0];
          9'h003:  h_byte = len_r;
          default: h_byte = mem[AW'(h_sel - twh_pkg::QUERY_HDR)];
        endcase
      end
    endcase
  end

  // Host reply transmitter.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      host_tx_valid <= 1'b0;
      host_tx_data  <= 8'h00;
      host_tx_last  <= 1'b0;
      h_idx         <= 9'h000;
      h_kind        <= twh_pkg::REP_BUSY;
    end
    else if (ce)
    begin
      if (h_start)
      begin
        host_tx_valid <= 1'b1;
        host_tx_data  <= h_byte;
        host_tx_last  <= (h_total == 9'h001);
        h_idx         <= 9'h000;
        h_kind        <= h_kind_new;
      end
      else if (host_tx_valid && host_tx_ready)
      begin
        if (host_tx_last)
        begin
          host_tx_valid <= 1'b0;
          host_tx_last  <= 1'b0;
        end
        else
        begin
          host_tx_data <= h_byte;
          host_tx_last <= (h_idx + 9'h002 == h_total);
          h_idx        <= h_idx + 9'h001;
        end
      end
    end
  end

  // Reader/writer response byte.
  always_comb
  begin
    r_sel   = r_start ? 4'h0 : r_idx + 4'h1;
    r_total = type_b_r ? twh_pkg::TYPEB_RESP_LEN : twh_pkg::JIS_RESP_LEN;
    r_byte  = twh_pkg::RF_WRITE_RESP;
    // The first byte goes out before the outcome register is loaded.
    ok_sel  = r_start ? (host_cmd_code == twh_pkg::CMD_ANSWER_OK) : ans_ok;
    if (type_b_r)
      r_byte = (r_sel == 4'h0) ?
               (ok_sel ? twh_pkg::SW1_OK : twh_pkg::SW1_ERR) :
               (ok_sel ? twh_pkg::SW2_OK : twh_pkg::SW2_ERR);
    else if (r_sel == 4'h0)
      r_byte = twh_pkg::RF_WRITE_RESP;
    else if (r_sel <= 4'(twh_pkg::ID_BYTES))
      r_byte = card_id[8 * (twh_pkg::ID_BYTES - int'(r_sel)) +: 8];
    else if (r_sel == 4'h9)
      r_byte = ok_sel ? twh_pkg::FLAG1_OK : twh_pkg::FLAG1_ERR;
    else
      r_byte = ok_sel ? twh_pkg::FLAG2_OK : twh_pkg::FLAG2_ERR;
  end

  // Reader/writer response transmitter; carrier loss aborts it.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rf_tx_valid <= 1'b0;
      rf_tx_data  <= 8'h00;
      rf_tx_last  <= 1'b0;
      r_idx       <= 4'h0;
    end
    else if (ce)
    begin
      if (lost)
      begin
        rf_tx_valid <= 1'b0;
        rf_tx_last  <= 1'b0;
      end
      else if (r_start)
      begin
        rf_tx_valid <= 1'b1;
        rf_tx_data  <= r_byte;
        rf_tx_last  <= 1'b0;
        r_idx       <= 4'h0;
      end
      else if (rf_tx_valid && rf_tx_ready)
      begin
        if (rf_tx_last)
        begin
          rf_tx_valid <= 1'b0;
          rf_tx_last  <= 1'b0;
        end
        else
        begin
          rf_tx_data <= r_byte;
          rf_tx_last <= (r_idx + 4'h2 == r_total);
          r_idx      <= r_idx + 4'h1;
        end
      end
    end
  end

  // Tunnel sequence.
  always_ff @(posedge mclk)
  begin
    if (rst)
      state <= twh_pkg::ST_IDLE;
    else if (lost)
      state <= twh_pkg::ST_IDLE;
    else if (ce)
    begin
      unique case (state)
        twh_pkg::ST_IDLE:
          if (rf_cmd_start && carrier_q && !serial_busy)
            state <= twh_pkg::ST_RF_RX;
        twh_pkg::ST_RF_RX:
          if (go_irq)
            state <= twh_pkg::ST_WAIT_QUERY;
        twh_pkg::ST_WAIT_QUERY:
          if (h_start && h_kind_new == twh_pkg::REP_QUERY)
            state <= twh_pkg::ST_SEND_QUERY;
        twh_pkg::ST_SEND_QUERY:
          if (host_tx_valid && host_tx_ready && host_tx_last)
            state <= twh_pkg::ST_ANSWER_WAIT;
        twh_pkg::ST_ANSWER_WAIT:
          if (r_start)
            state <= twh_pkg::ST_RF_RESP;
          else if (awt_expired)
            state <= twh_pkg::ST_IDLE;
        twh_pkg::ST_RF_RESP:
          if (rf_tx_valid && rf_tx_ready && rf_tx_last)
            state <= twh_pkg::ST_IDLE;
      endcase
    end
  end

  // Payload capture, outcome and control flags.
  always_ff @(posedge mclk)
  begin
    if (ce && state == twh_pkg::ST_RF_RX && rf_data_valid)
      mem[wptr] <= rf_data;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wptr      <= '0;
      addr_r    <= 16'h0000;
      len_r     <= 8'h00;
      type_b_r  <= 1'b0;
      done_seen <= 1'b0;
      ans_ok    <= 1'b0;
    end
    else if (ce)
    begin
      if (state == twh_pkg::ST_IDLE && rf_cmd_start)
      begin
        wptr      <= '0;
        addr_r    <= rf_wr_addr;
        len_r     <= rf_wr_len;
        type_b_r  <= rf_type_b;
        done_seen <= 1'b0;
      end
      else if (state == twh_pkg::ST_RF_RX)
      begin
        if (rf_data_valid)
          wptr <= wptr + AW'(1);
        if (rf_cmd_done)
          done_seen <= 1'b1;
      end
      if (r_start)
        ans_ok <= (host_cmd_code == twh_pkg::CMD_ANSWER_OK);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      host_interrupt_out_n <= 1'b1;
      host_cmd_fwd         <= 1'b0;
      excl_active          <= 1'b0;
    end
    else if (ce)
    begin
      if (lost || (h_start && h_kind_new == twh_pkg::REP_QUERY))
        host_interrupt_out_n <= 1'b1;
      else if (go_irq)
        host_interrupt_out_n <= 1'b0;
      host_cmd_fwd <= fwd;
      excl_active  <= serial_busy || (state != twh_pkg::ST_IDLE) ||
                      (rf_cmd_start && carrier_q);
    end
  end

  // Checks.
  sequence query_hdr_s;
    host_tx_valid && host_tx_data == twh_pkg::STATUS_OK;
  endsequence

  query_format_a: assert property (@(posedge mclk) disable iff (rst)
    h_start && h_kind_new == twh_pkg::REP_QUERY
    |=> query_hdr_s ##0 !host_tx_last)
    else $error("query reply does not open with status byte");

  status_single_a: assert property (@(posedge mclk) disable iff (rst)
    h_start && h_kind_new == twh_pkg::REP_STATUS
    |=> host_tx_valid && host_tx_last &&
        host_tx_data == twh_pkg::STATUS_OK)
    else $error("answer reply is not one status byte");

  rf_resp_code_a: assert property (@(posedge mclk) disable iff (rst)
    r_start && !type_b_r && !lost
    |=> rf_tx_valid && rf_tx_data == twh_pkg::RF_WRITE_RESP && !rf_tx_last)
    else $error("rf write response code wrong");

  rf_window_a: assert property (@(posedge mclk) disable iff (rst)
    rf_tx_valid |-> excl_active && state == twh_pkg::ST_RF_RESP)
    else $error("rf response outside exclusive window");

  busy_reply_a: assert property (@(posedge mclk) disable iff (rst)
    hcmd && (state == twh_pkg::ST_RF_RX || state == twh_pkg::ST_RF_RESP)
    |=> host_tx_valid && host_tx_data == twh_pkg::STATUS_BUSY)
    else $error("no busy reply during exclusive control");

  unknown_busy_a: assert property (@(posedge mclk) disable iff (rst)
    hcmd && state == twh_pkg::ST_IDLE && !host_code_known
    |=> host_tx_data == twh_pkg::STATUS_BUSY && !host_cmd_fwd)
    else $error("unknown code not answered busy");

  serial_quiet_a: assert property (@(posedge mclk) disable iff (rst)
    ce && serial_busy && state == twh_pkg::ST_IDLE
    |=> state == twh_pkg::ST_IDLE && excl_active)
    else $error("rf command accepted during serial processing");

  irq_order_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(host_interrupt_out_n) |-> $past(!host_tx_valid) && $past(!hcmd))
    else $error("interrupt raised while busy reply pending");

  query_only_a: assert property (@(posedge mclk) disable iff (rst)
    hcmd && state == twh_pkg::ST_WAIT_QUERY &&
    host_cmd_code != twh_pkg::CMD_QUERY && !lost
    |=> host_tx_data == twh_pkg::STATUS_BUSY &&
        state == twh_pkg::ST_WAIT_QUERY)
    else $error("non-query after interrupt not busy");

  carrier_idle_a: assert property (@(posedge mclk) disable iff (rst)
    lost |=> state == twh_pkg::ST_IDLE && host_interrupt_out_n &&
             !rf_tx_valid)
    else $error("carrier loss did not return to idle");

  awt_hold_a: assert property (@(posedge mclk) disable iff (rst)
    awt_restart && !lost
    |=> state == twh_pkg::ST_ANSWER_WAIT && !awt_expired)
    else $error("answer wait expired right after busy reply");

  answer_leave_a: assert property (@(posedge mclk) disable iff (rst)
    r_start && !lost |=> state == twh_pkg::ST_RF_RESP ##1
    state != twh_pkg::ST_ANSWER_WAIT)
    else $error("answer did not end answer wait");

endmodule
`default_nettype wire

// [verification/twh_host_model.sv]
`default_nettype none
module twh_host_model (
  // Clock
  input  wire logic       mclk,
  // Command bytes
  output logic            host_cmd_valid,
  output logic [7:0]      host_cmd_code,
  output logic            host_addr_match,
  output logic            host_code_known,
  // Reply bytes
  input  wire logic       host_cmd_fwd,
  input  wire logic       host_tx_valid,
  input  wire logic [7:0] host_tx_data,
  input  wire logic       host_tx_last,
  output logic            host_tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;

  logic       slow;
  logic       fwd_seen;
  logic [7:0] rx_q [$];

  initial
  begin
    host_cmd_valid = 1'b0;
    host_cmd_code = 8'h00;
    host_addr_match = 1'b0;
    host_code_known = 1'b0;
    host_tx_ready = 1'b1;
    slow = 1'b0;
    fwd_seen = 1'b0;
  end

  // Sends one code byte and gathers the reply until its last byte.
  task automatic cmd(input logic [7:0] code, input logic known,
                     input logic match);
    int t;
    t = 0;
    rx_q.delete();
    fwd_seen = 1'b0;
    host_cmd_valid <= 1'b1;
    host_cmd_code <= code;
    host_addr_match <= match;
    host_code_known <= known;
    @(posedge mclk);
    host_cmd_valid <= 1'b0;
    host_cmd_code <= ~code;
    while (t < 30)
    begin
      @(posedge mclk);
      t++;
      host_tx_ready <= slow ? ~host_tx_ready : 1'b1;
      if (host_cmd_fwd === 1'b1)
        fwd_seen = 1'b1;
      if (host_tx_valid === 1'b1 && host_tx_ready === 1'b1)
      begin
        rx_q.push_back(host_tx_data);
        if (host_tx_last === 1'b1)
          t = 30;
      end
    end
  endtask
endmodule
`default_nettype wire

// [verification/test_tunnel_write_host_handshake.sv]
`default_nettype none
module test_tunnel_write_host_handshake;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int          AWT = 50;
  localparam logic [15:0] WA = 16'h1a2b;
  localparam logic [63:0] CARD = 64'h0123_4567_89ab_cdef;

  logic mclk, rst, ce, cv, am, ck, serial_busy, fwd, tv, tl, tr, irq_n;
  logic rf_carrier, rf_cmd_start, rf_type_b, rf_data_valid, rf_cmd_done;
  logic rf_tx_valid, rf_tx_last, rf_tx_ready, excl_active;
  logic [7:0]  cc, td, rf_wr_len, rf_data, rf_tx_data;
  logic [15:0] rf_wr_addr;
  logic [7:0]  rf_q [$];
  logic [7:0]  exp_q [$];
  int          n_mismatch = 0;
  int          cmp_count = 0;

  twh_core #(.AWT_COUNT(AWT)) dut (.mclk(mclk), .rst(rst), .ce(ce),
    .host_cmd_valid(cv), .host_cmd_code(cc), .host_addr_match(am),
    .host_code_known(ck), .serial_busy(serial_busy), .host_cmd_fwd(fwd),
    .host_tx_valid(tv), .host_tx_data(td), .host_tx_last(tl),
    .host_tx_ready(tr), .host_interrupt_out_n(irq_n),
    .rf_carrier(rf_carrier), .rf_cmd_start(rf_cmd_start),
    .rf_type_b(rf_type_b), .rf_wr_addr(rf_wr_addr), .rf_wr_len(rf_wr_len),
    .rf_data_valid(rf_data_valid), .rf_data(rf_data),
    .rf_cmd_done(rf_cmd_done), .card_id(CARD), .rf_tx_valid(rf_tx_valid),
    .rf_tx_data(rf_tx_data), .rf_tx_last(rf_tx_last),
    .rf_tx_ready(rf_tx_ready), .excl_active(excl_active));

  twh_host_model host (.mclk(mclk), .host_cmd_valid(cv), .host_cmd_code(cc),
    .host_addr_match(am), .host_code_known(ck), .host_cmd_fwd(fwd),
    .host_tx_valid(tv), .host_tx_data(td), .host_tx_last(tl),
    .host_tx_ready(tr));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // The reader/writer side stalls every other cycle.
  always @(posedge mclk)
  begin
    rf_tx_ready <= !rst && !rf_tx_ready;
    if (rf_tx_valid === 1'b1 && rf_tx_ready === 1'b1)
      rf_q.push_back(rf_tx_data);
  end

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic busy(input logic [7:0] code, input logic known);
    host.cmd(code, known, 1'b1);
    check("busy len", 8'(host.rx_q.size()), 8'h01);
    check("busy code", host.rx_q[0], twh_pkg::STATUS_BUSY);
  endtask

  // Tunnel write of two payload bytes, optionally probed by the host.
  task automatic rf_write(input logic tb, input logic probe);
    rf_type_b <= tb;
    rf_wr_addr <= WA;
    rf_wr_len <= 8'h02;
    rf_cmd_start <= 1'b1;
    @(posedge mclk);
    rf_cmd_start <= 1'b0;
    rf_data_valid <= 1'b1;
    rf_data <= 8'ha5;
    @(posedge mclk);
    rf_data <= 8'h5a;
    @(posedge mclk);
    rf_data_valid <= 1'b0;
    rf_data <= 8'ha5;
    check("excl rx", {7'h00, excl_active}, 8'h01);
    if (probe)
    begin
      busy(8'h11, 1'b1);
      check("irq early", {7'h00, irq_n}, 8'h01);
    end
    rf_cmd_done <= 1'b1;
    @(posedge mclk);
    rf_cmd_done <= 1'b0;
    for (int i = 0; i < 10 && irq_n !== 1'b0; i++)
      @(posedge mclk);
    check("irq", {7'h00, irq_n}, 8'h00);
  endtask

  task automatic do_query;
    logic [7:0] e [6];
    e = '{twh_pkg::STATUS_OK, WA[15:8], WA[7:0], 8'h02, 8'ha5, 8'h5a};
    host.cmd(twh_pkg::CMD_QUERY, 1'b1, 1'b1);
    check("query len", 8'(host.rx_q.size()), 8'h06);
    for (int i = 0; i < 6; i++)
      check("query byte", host.rx_q[i], e[i]);
  endtask

  task automatic do_answer(input logic [7:0] code, input logic tb,
                           input logic ok);
    exp_q.delete();
    if (tb)
    begin
      exp_q.push_back(ok ? twh_pkg::SW1_OK : twh_pkg::SW1_ERR);
      exp_q.push_back(ok ? twh_pkg::SW2_OK : twh_pkg::SW2_ERR);
    end
    else
    begin
      exp_q.push_back(twh_pkg::RF_WRITE_RESP);
      for (int i = 7; i >= 0; i--)
        exp_q.push_back(CARD[8*i +: 8]);
      exp_q.push_back(ok ? twh_pkg::FLAG1_OK : twh_pkg::FLAG1_ERR);
      exp_q.push_back(ok ? twh_pkg::FLAG2_OK : twh_pkg::FLAG2_ERR);
    end
    rf_q.delete();
    host.cmd(code, 1'b1, 1'b1);
    check("answer len", 8'(host.rx_q.size()), 8'h01);
    check("answer code", host.rx_q[0], twh_pkg::STATUS_OK);
    for (int i = 0; i < 60 && rf_q.size() < exp_q.size(); i++)
      @(posedge mclk);
    check("rf len", 8'(rf_q.size()), 8'(exp_q.size()));
    for (int i = 0; i < exp_q.size(); i++)
      check("rf byte", rf_q[i], exp_q[i]);
    repeat (4) @(posedge mclk);
    check("excl end", {7'h00, excl_active}, 8'h00);
  endtask

  task automatic t_serial;
    host.cmd(8'h11, 1'b1, 1'b1);
    check("fwd", {7'h00, host.fwd_seen}, 8'h01);
    check("fwd len", 8'(host.rx_q.size()), 8'h00);
    busy(8'h22, 1'b0);
    serial_busy <= 1'b1;
    busy(8'h11, 1'b1);
    rf_cmd_start <= 1'b1;
    @(posedge mclk);
    rf_cmd_start <= 1'b0;
    rf_cmd_done <= 1'b1;
    @(posedge mclk);
    rf_cmd_done <= 1'b0;
    repeat (5) @(posedge mclk);
    check("rf ignored", {7'h00, irq_n}, 8'h01);
    serial_busy <= 1'b0;
    host.cmd(8'h11, 1'b1, 1'b0);
    check("no match", 8'(host.rx_q.size()), 8'h00);
    check("no match fwd", {7'h00, host.fwd_seen}, 8'h00);
    $display("test serial done");
  endtask

  task automatic t_tunnel(input logic tb, input logic [7:0] code,
                          input logic slow);
    host.slow = slow;
    rf_write(tb, 1'b1);
    busy(8'h11, 1'b1);
    busy(twh_pkg::CMD_ANSWER_OK, 1'b1);
    check("excl", {7'h00, excl_active}, 8'h01);
    do_query;
    check("irq off", {7'h00, irq_n}, 8'h01);
    do_answer(code, tb, code == twh_pkg::CMD_ANSWER_OK);
    host.slow = 1'b0;
    $display("test tunnel done");
  endtask

  task automatic t_carrier;
    rf_write(1'b0, 1'b0);
    rf_carrier <= 1'b0;
    repeat (5) @(posedge mclk);
    check("irq lost", {7'h00, irq_n}, 8'h01);
    check("excl lost", {7'h00, excl_active}, 8'h00);
    rf_carrier <= 1'b1;
    repeat (3) @(posedge mclk);
    busy(twh_pkg::CMD_QUERY, 1'b0);
    $display("test carrier done");
  endtask

  task automatic t_timeout;
    rf_write(1'b0, 1'b0);
    do_query;
    repeat (3)
    begin
      repeat (25) @(posedge mclk);
      busy(8'h11, 1'b1);
    end
    do_answer(twh_pkg::CMD_ANSWER_OK, 1'b0, 1'b1);
    rf_write(1'b0, 1'b0);
    do_query;
    repeat (AWT + 10) @(posedge mclk);
    host.cmd(twh_pkg::CMD_ANSWER_OK, 1'b1, 1'b1);
    check("timed out", {7'h00, host.fwd_seen}, 8'h01);
    $display("test timeout done");
  endtask

  initial
  begin
    #1000000;
    n_mismatch++;
    end_of_test;
  end

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    serial_busy = 1'b0;
    rf_carrier = 1'b1;
    rf_cmd_start = 1'b0;
    rf_type_b = 1'b0;
    rf_wr_addr = 16'h0000;
    rf_wr_len = 8'h00;
    rf_data_valid = 1'b0;
    rf_data = 8'h00;
    rf_cmd_done = 1'b0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_serial;
    t_tunnel(1'b0, twh_pkg::CMD_ANSWER_OK, 1'b0);
    t_tunnel(1'b1, twh_pkg::CMD_ANSWER_ERR, 1'b1);
    t_carrier;
    t_timeout;
    end_of_test;
  end
endmodule
`default_nettype wire
